/* File: rtl/iss_pkg.sv */
// Package with the status model constants: bit positions, reset values, codes and commands.
package iss_pkg;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ESR_USED_MASK = 8'hB5;
  localparam logic [7:0] STB_USED_MASK = 8'h70;
  localparam int ESR_PON_BIT = 7;
  localparam int ESR_CMD_ERR_BIT = 5;
  localparam int ESR_EXE_ERR_BIT = 4;
  localparam int ESR_QRY_ERR_BIT = 2;
  localparam int ESR_OPC_BIT = 0;
  localparam int STB_SERVICE_BIT = 6;
  localparam int STB_EVENT_BIT = 5;
  localparam int STB_MESSAGE_BIT = 4;
  localparam logic [7:0] QERR_NONE = 8'h00;
  localparam logic [7:0] QERR_INTERRUPTED = 8'h01;
  localparam logic [7:0] QERR_DEADLOCK = 8'h02;
  localparam logic [7:0] QERR_UNTERMINATED = 8'h03;
  localparam logic [2:0] PPE_PATTERN = 3'h6;
  localparam int PPE_SENSE_BIT = 3;
  localparam int PPE_PATTERN_HI = 6;
  localparam int PPE_PATTERN_LO = 4;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] EXE_ERR_RESET = 8'h00;
  // Register query selectors on the command port.
  typedef enum logic [2:0] {
    ISS_SEL_ESR = 3'h0,
    ISS_SEL_ESE = 3'h1,
    ISS_SEL_STB = 3'h2,
    ISS_SEL_SRE = 3'h3,
    ISS_SEL_PRE = 3'h4,
    ISS_SEL_QERR = 3'h5,
    ISS_SEL_EXE = 3'h6,
    ISS_SEL_NONE = 3'h7
  } iss_sel_e;
  // Common command writes.
  typedef enum logic [1:0] {
    ISS_WR_ESE = 2'h0,
    ISS_WR_SRE = 2'h1,
    ISS_WR_PRE = 2'h2,
    ISS_WR_NONE = 2'h3
  } iss_wr_e;
endpackage

/* File: rtl/iss_ppoll.sv */
// Parallel poll configuration decoder and response line driver.
module iss_ppoll (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ppc_seen,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic ppu_seen,
  input wire logic ist,
  input wire logic poll_active,
  output logic [7:0] ppr_dio,
  output logic configured
);
  logic sense;
  logic [2:0] line_pos;
  logic armed;
  logic [7:0] next_dio;

  // A configure command arms the decoder; the very next command byte must be the enable.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b0;
      configured <= 1'b0;
      sense <= 1'b0;
      line_pos <= 3'h0;
    end else if (ppu_seen) begin
      armed <= 1'b0;
      configured <= 1'b0;
    end else if (ppc_seen) begin
      armed <= 1'b1;
    end else if (armed && cmd_valid) begin
      armed <= 1'b0;
      // Bit 7 of the enable byte is a don't care.
      if (cmd_byte[iss_pkg::PPE_PATTERN_HI:iss_pkg::PPE_PATTERN_LO] == iss_pkg::PPE_PATTERN) begin // R5
        configured <= 1'b1;
        sense <= cmd_byte[iss_pkg::PPE_SENSE_BIT]; // R5
        line_pos <= cmd_byte[2:0]; // R5
      end
    end
  end

  // A line is asserted only when ist matches the configured sense; others stay passive.
  always_comb begin
    next_dio = 8'h00;
    if (poll_active && configured && (ist == sense)) begin
      next_dio[line_pos] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ppr_dio <= 8'h00;
    end else begin
      ppr_dio <= next_dio;
    end
  end
endmodule

/* File: rtl/iss_status.sv */
// Status reporting, query error handling and parallel poll for the instrument bus interface.
// Function
// R1: Talk addressed, formatter idle, queue empty: query error, code 3, reset parser.
// R2: Pending response with terminator or two ENDs: query error, code 1, reset formatter.
// R3: Pending response and full queue: query error, code 2, reset formatter, resume.
// R4: ist is one when parallel poll mask AND status byte is nonzero.
// R5: Enable byte: pattern 110 in bits 6..4, sense bit 3, line in 2..0.
// R6: Controller sends configure command, then the enable byte.
// R7: Event summary bit 5 set when any enabled event status bit is set.
// R8: Event status query returns and clears; enable mask written and read back.
// R9: Event status bit 7 set at power on.
// R10: Syntax error sets event bit 5 and resets the parser.
// R11: Execution failure sets event bit 4 and records the error number.
// R12: Query errors set event bit 2 with cause code in query error register.
// R13: Operation complete command sets event bit 0.
// R14: Service summary bit set and request asserted when enabled status bit set.
// R15: Status query returns summary in bit 6; serial poll returns request bit.
// R16: Message ready bit 4 set on formatted response, cleared after terminator.
// R17: Service request and parallel poll masks written and read by their commands.
// R18: Handshake, service request, remote-local, poll, clear, trigger; no controller.
// R19: Power on: masks, status, error codes zero; event status holds 128.
// R20: Unused event status and status byte bits read zero, cannot be set.
// R21: Request bit clears after serial poll; summary persists while cause remains.
module iss_status (
  input wire logic clk,
  input wire logic rstn,
  // Parser and formatter events.
  input wire logic talk_addressed,
  input wire logic formatter_active,
  input wire logic response_ready,
  input wire logic terminator_sent,
  input wire logic queue_empty,
  input wire logic queue_full,
  input wire logic terminator_parsed,
  input wire logic multi_end,
  input wire logic syntax_error,
  input wire logic exec_error,
  input wire logic [7:0] exec_error_code,
  input wire logic opc_cmd,
  // Common command register port.
  input wire logic [1:0] wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_sel,
  input wire logic rd_strobe,
  // Bus side.
  input wire logic serial_poll,
  input wire logic ppc_seen,
  input wire logic ppu_seen,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic poll_active,
  input wire logic device_clear,
  input wire logic device_trigger,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] spoll_byte,
  output logic srq,
  output logic parser_reset,
  output logic formatter_reset,
  output logic trigger_pulse,
  output logic [7:0] ppr_dio,
  output logic pp_configured
);
  logic [7:0] event_status;
  logic [7:0] event_enable;
  logic [7:0] service_enable;
  logic [7:0] ppoll_enable;
  logic [7:0] query_error;
  logic [7:0] exec_error_reg;
  logic message_ready;
  logic service_request;
  logic ist;
  logic q_unterminated;
  logic q_interrupted;
  logic q_deadlock;
  logic q_any;
  logic esr_read;
  logic [7:0] event_set;
  logic [7:0] status_core;
  logic summary;
  logic [7:0] stb_query;
  logic [7:0] next_rd;
  logic [7:0] next_event_status;
  logic [7:0] next_query_error;
  logic next_message_ready;

  assign q_unterminated = talk_addressed && !formatter_active && queue_empty; // R1
  assign q_interrupted = formatter_active && (terminator_parsed || multi_end); // R2
  assign q_deadlock = formatter_active && queue_full && !q_interrupted; // R3
  assign q_any = q_unterminated || q_interrupted || q_deadlock;
  assign esr_read = rd_strobe && (rd_sel == iss_pkg::ISS_SEL_ESR);

  always_comb begin
    event_set = 8'h00;
    event_set[iss_pkg::ESR_CMD_ERR_BIT] = syntax_error; // R10
    event_set[iss_pkg::ESR_EXE_ERR_BIT] = exec_error; // R11
    event_set[iss_pkg::ESR_QRY_ERR_BIT] = q_any; // R12
    event_set[iss_pkg::ESR_OPC_BIT] = opc_cmd; // R13
  end

  // A read clears the register, but an event landing in the same cycle survives it.
  always_comb begin
    next_event_status = event_status | event_set;
    if (esr_read) begin
      next_event_status = event_set; // R8
    end
    next_event_status = next_event_status & iss_pkg::ESR_USED_MASK; // R20
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_status <= iss_pkg::ESR_RESET; // R9 R19
    end else begin
      event_status <= next_event_status;
    end
  end

  // The event mask changes only on its set command.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_enable <= iss_pkg::MASK_RESET; // R19
    end else if (wr_sel == iss_pkg::ISS_WR_ESE) begin
      event_enable <= wr_data; // R8
    end
  end

  // The service mask changes only on its set command.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      service_enable <= iss_pkg::MASK_RESET; // R19
    end else if (wr_sel == iss_pkg::ISS_WR_SRE) begin
      service_enable <= wr_data; // R17
    end
  end

  // The poll mask changes only on its set command.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ppoll_enable <= iss_pkg::MASK_RESET; // R19
    end else if (wr_sel == iss_pkg::ISS_WR_PRE) begin
      ppoll_enable <= wr_data; // R17
    end
  end

  // Interruption wins the code over a full queue; unterminated cannot coincide, since the others need a pending response.
  always_comb begin
    next_query_error = query_error;
    if (q_deadlock) begin
      next_query_error = iss_pkg::QERR_DEADLOCK; // R3 R12
    end
    if (q_interrupted) begin
      next_query_error = iss_pkg::QERR_INTERRUPTED; // R2 R12
    end
    if (q_unterminated) begin
      next_query_error = iss_pkg::QERR_UNTERMINATED; // R1 R12
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      query_error <= iss_pkg::QERR_NONE; // R19
    end else begin
      query_error <= next_query_error;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exec_error_reg <= iss_pkg::EXE_ERR_RESET; // R19
    end else if (exec_error) begin
      exec_error_reg <= exec_error_code; // R11
    end
  end

  // The parser restarts one cycle after any cause that makes it lose its place.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      parser_reset <= 1'b0;
    end else begin
      parser_reset <= q_unterminated || syntax_error || device_clear; // R1 R10 R18
    end
  end

  // The formatter is flushed one cycle after a query error that strands a response.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      formatter_reset <= 1'b0;
    end else begin
      formatter_reset <= q_interrupted || q_deadlock || device_clear; // R2 R3
    end
  end

  // A formatter reset discards the response, so message ready drops with it; a new one wins.
  always_comb begin
    next_message_ready = message_ready;
    if (terminator_sent || formatter_reset) begin
      next_message_ready = 1'b0; // R16
    end
    if (response_ready) begin
      next_message_ready = 1'b1; // R16
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      message_ready <= 1'b0;
    end else begin
      message_ready <= next_message_ready;
    end
  end

  always_comb begin
    status_core = 8'h00;
    status_core[iss_pkg::STB_EVENT_BIT] = |(event_status & event_enable); // R7
    status_core[iss_pkg::STB_MESSAGE_BIT] = message_ready;
    summary = |(status_core & service_enable & ~(8'h01 << iss_pkg::STB_SERVICE_BIT)); // R14
    stb_query = status_core & iss_pkg::STB_USED_MASK; // R20
    stb_query[iss_pkg::STB_SERVICE_BIT] = summary; // R15
  end

  // The request follows an enabled cause and is held until a serial poll reports it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      service_request <= 1'b0;
    end else if (serial_poll) begin
      service_request <= 1'b0; // R21
    end else if (summary) begin
      service_request <= 1'b1; // R14
    end
  end

  // The bus request line drops in the cycle after the poll that reports it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      srq <= 1'b0;
    end else begin
      srq <= service_request && !serial_poll; // R14
    end
  end

  // Serial poll returns the request bit captured before it clears.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spoll_byte <= 8'h00;
    end else if (serial_poll) begin
      spoll_byte <= {stb_query[7], service_request, stb_query[5:0]}; // R15
    end
  end

  assign ist = |(ppoll_enable & stb_query); // R4

  always_comb begin
    unique case (rd_sel)
      iss_pkg::ISS_SEL_ESR: next_rd = event_status; // R8
      iss_pkg::ISS_SEL_ESE: next_rd = event_enable; // R8
      iss_pkg::ISS_SEL_STB: next_rd = stb_query; // R15
      iss_pkg::ISS_SEL_SRE: next_rd = service_enable; // R17
      iss_pkg::ISS_SEL_PRE: next_rd = ppoll_enable; // R17
      iss_pkg::ISS_SEL_QERR: next_rd = query_error;
      iss_pkg::ISS_SEL_EXE: next_rd = exec_error_reg;
      iss_pkg::ISS_SEL_NONE: next_rd = 8'h00;
    endcase
  end

  // Every read strobe is answered exactly one cycle later.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_strobe;
    end
  end

  // Read data holds until the next read so a slow parser can still pick it up.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else if (rd_strobe) begin
      rd_data <= next_rd;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trigger_pulse <= 1'b0;
    end else begin
      trigger_pulse <= device_trigger; // R18
    end
  end

  // The controller is expected to send the configure command before the enable byte.
  iss_ppoll u_ppoll ( // R6 R18
    .clk(clk),
    .rstn(rstn),
    .ppc_seen(ppc_seen),
    .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte),
    .ppu_seen(ppu_seen),
    .ist(ist),
    .poll_active(poll_active),
    .ppr_dio(ppr_dio),
    .configured(pp_configured)
  );
endmodule

/* File: verif/iss_status_properties.sv */
// Port-level assertions for the status block.
module iss_status_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic talk_addressed,
  input wire logic formatter_active,
  input wire logic queue_empty,
  input wire logic queue_full,
  input wire logic terminator_parsed,
  input wire logic multi_end,
  input wire logic syntax_error,
  input wire logic [2:0] rd_sel,
  input wire logic rd_strobe,
  input wire logic serial_poll,
  input wire logic poll_active,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic srq,
  input wire logic parser_reset,
  input wire logic formatter_reset,
  input wire logic [7:0] ppr_dio
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_read_answer: assert property (rd_strobe |=> rd_valid)
    else $error("read not answered");
  chk_unterm_reset: assert property (talk_addressed && !formatter_active && queue_empty |=> parser_reset)
    else $error("no parser reset on empty talk");
  chk_syntax_reset: assert property (syntax_error |=> parser_reset)
    else $error("no parser reset on syntax fault");
  chk_interrupt_flush: assert property (formatter_active && (terminator_parsed || multi_end) |=> formatter_reset)
    else $error("no flush on interruption");
  chk_deadlock_flush: assert property (formatter_active && queue_full |=> formatter_reset)
    else $error("no flush on full queue");
  chk_esr_unused: assert property (rd_valid && $past(rd_sel) == iss_pkg::ISS_SEL_ESR |-> (rd_data & ~iss_pkg::ESR_USED_MASK) == 8'h00)
    else $error("unused event bit read as one");
  chk_poll_drop: assert property (serial_poll |=> !srq)
    else $error("request held after serial poll");
  chk_ppr_quiet: assert property (!poll_active |=> ppr_dio == 8'h00)
    else $error("poll lines driven outside a poll");
  cover property (rd_valid);
  cover property (srq ##1 serial_poll);
  cover property (ppr_dio != 8'h00);
endmodule

bind iss_status iss_status_properties iss_status_properties_i (.*);

/* File: verif/iss_ctrl_model.sv */
// Bus controller model issuing serial polls, parallel poll set-up and poll cycles.
module iss_ctrl_model (
  input wire logic clk,
  output logic serial_poll,
  output logic ppc_seen,
  output logic ppu_seen,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic poll_active
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_poll = 1'b0;
    ppc_seen = 1'b0;
    ppu_seen = 1'b0;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    poll_active = 1'b0;
  end
  // One-cycle bus command: bit 2 serial poll, bit 1 configure, bit 0 unconfigure.
  task automatic strobe(input logic [2:0] which);
    serial_poll <= which[2];
    ppc_seen <= which[1];
    ppu_seen <= which[0];
    @(posedge clk);
    serial_poll <= 1'b0;
    ppc_seen <= 1'b0;
    ppu_seen <= 1'b0;
  endtask
  task automatic configure(input logic [7:0] b);
    strobe(3'h2);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // A released data bus does not keep the last byte.
    cmd_byte <= ~b;
  endtask
  task automatic unconfig;
    strobe(3'h1);
  endtask
  task automatic spoll;
    strobe(3'h4);
  endtask
  task automatic poll(input logic on);
    poll_active <= on;
    repeat (2) @(posedge clk);
  endtask
endmodule

/* File: verif/iss_status_bench.sv */
// Self-checking bench for the status block.
module iss_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, talk_addressed, formatter_active, response_ready, terminator_sent;
  logic queue_empty, queue_full, terminator_parsed, multi_end, syntax_error, exec_error;
  logic opc_cmd, rd_strobe, device_clear, device_trigger, serial_poll, ppc_seen, ppu_seen;
  logic cmd_valid, poll_active, rd_valid, srq, parser_reset, formatter_reset, trigger_pulse;
  logic pp_configured;
  logic [7:0] exec_error_code, wr_data, cmd_byte, rd_data, spoll_byte, ppr_dio;
  logic [1:0] wr_sel;
  logic [2:0] rd_sel;
  int miscompares = 0;
  int total_checks = 0;
  iss_status iss_status_i (.*);
  iss_ctrl_model iss_ctrl_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Results of one edge are read at the next edge, before its updates land.
  task step;
    @(posedge clk);
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task rd(input logic [2:0] s, input logic [7:0] e);
    rd_sel <= s;
    rd_strobe <= 1'b1;
    step;
    rd_strobe <= 1'b0;
    step;
    chk("rd_data", rd_data, e);
    chk("rd_valid", {7'h00, rd_valid}, 8'h01);
  endtask
  task wr(input logic [1:0] s, input logic [7:0] d);
    wr_sel <= s;
    wr_data <= d;
    step;
    wr_sel <= iss_pkg::ISS_WR_NONE;
    step;
  endtask
  // One cycle of events: ready, sent, syntax, exec, complete, clear, trigger.
  task pulse(input logic [6:0] v, input logic [7:0] code);
    response_ready <= v[6];
    terminator_sent <= v[5];
    syntax_error <= v[4];
    exec_error <= v[3];
    opc_cmd <= v[2];
    device_clear <= v[1];
    device_trigger <= v[0];
    exec_error_code <= code;
    step;
    {response_ready, terminator_sent, syntax_error, exec_error} <= 4'h0;
    {opc_cmd, device_clear, device_trigger} <= 3'h0;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task t_reset;
    for (int i = 1; i < 8; i++) rd(i[2:0], 8'h00);
    rd(iss_pkg::ISS_SEL_ESR, 8'h80);
    rd(iss_pkg::ISS_SEL_ESR, 8'h00);
    $display("reset test done");
  endtask
  task t_events;
    pulse(7'h1C, 8'h2A);
    rd(iss_pkg::ISS_SEL_ESR, 8'h31);
    rd(iss_pkg::ISS_SEL_EXE, 8'h2A);
    $display("event test done");
  endtask
  task t_qerr;
    for (int k = 0; k < 4; k++) begin
      formatter_active <= (k != 3);
      multi_end <= (k == 0);
      terminator_parsed <= (k == 1);
      queue_full <= (k == 2);
      talk_addressed <= (k == 3);
      queue_empty <= (k == 3);
      step;
      {formatter_active, multi_end, terminator_parsed} <= 3'h0;
      {queue_full, talk_addressed, queue_empty} <= 3'h0;
      rd(iss_pkg::ISS_SEL_QERR, (k == 0) ? 8'h01 : 8'(k));
      rd(iss_pkg::ISS_SEL_ESR, 8'h04);
    end
    $display("query error test done");
  endtask
  task t_service;
    wr(iss_pkg::ISS_WR_ESE, 8'h04);
    wr(iss_pkg::ISS_WR_SRE, 8'h20);
    rd(iss_pkg::ISS_SEL_ESE, 8'h04);
    rd(iss_pkg::ISS_SEL_SRE, 8'h20);
    talk_addressed <= 1'b1;
    queue_empty <= 1'b1;
    step;
    talk_addressed <= 1'b0;
    queue_empty <= 1'b0;
    repeat (4) step;
    chk("srq", {7'h00, srq}, 8'h01);
    rd(iss_pkg::ISS_SEL_STB, 8'h60);
    iss_ctrl_model_i.spoll();
    step;
    chk("spoll_byte", spoll_byte, 8'h60);
    chk("srq", {7'h00, srq}, 8'h00);
    repeat (3) step;
    chk("srq", {7'h00, srq}, 8'h01);
    rd(iss_pkg::ISS_SEL_ESR, 8'h04);
    repeat (3) step;
    rd(iss_pkg::ISS_SEL_STB, 8'h00);
    chk("srq", {7'h00, srq}, 8'h01);
    iss_ctrl_model_i.spoll();
    step;
    chk("spoll_byte", spoll_byte, 8'h40);
    chk("srq", {7'h00, srq}, 8'h00);
    $display("service test done");
  endtask
  task t_ppoll;
    wr(iss_pkg::ISS_WR_PRE, 8'h10);
    rd(iss_pkg::ISS_SEL_PRE, 8'h10);
    pulse(7'h40, 8'h00);
    rd(iss_pkg::ISS_SEL_STB, 8'h10);
    iss_ctrl_model_i.configure(8'hE8);
    iss_ctrl_model_i.configure(8'h4B);
    iss_ctrl_model_i.poll(1'b1);
    chk("ppr_dio", ppr_dio, 8'h01);
    iss_ctrl_model_i.poll(1'b0);
    iss_ctrl_model_i.configure(8'h63);
    iss_ctrl_model_i.poll(1'b1);
    chk("ppr_dio", ppr_dio, 8'h00);
    iss_ctrl_model_i.poll(1'b0);
    pulse(7'h20, 8'h00);
    rd(iss_pkg::ISS_SEL_STB, 8'h00);
    iss_ctrl_model_i.poll(1'b1);
    chk("ppr_dio", ppr_dio, 8'h08);
    iss_ctrl_model_i.poll(1'b0);
    iss_ctrl_model_i.unconfig();
    iss_ctrl_model_i.poll(1'b1);
    chk("ppr_dio", ppr_dio, 8'h00);
    chk("pp_configured", {7'h00, pp_configured}, 8'h00);
    iss_ctrl_model_i.poll(1'b0);
    $display("parallel poll test done");
  endtask
  task t_clear;
    pulse(7'h03, 8'h00);
    step;
    chk("resets", {6'h00, parser_reset, formatter_reset}, 8'h03);
    chk("trigger", {7'h00, trigger_pulse}, 8'h01);
    $display("clear test done");
  endtask
  initial begin
    {talk_addressed, formatter_active, response_ready, terminator_sent} = 4'h0;
    {queue_empty, queue_full, terminator_parsed, multi_end, syntax_error} = 5'h00;
    {exec_error, opc_cmd, rd_strobe, device_clear, device_trigger} = 5'h00;
    exec_error_code = 8'h00;
    wr_data = 8'h00;
    wr_sel = iss_pkg::ISS_WR_NONE;
    rd_sel = iss_pkg::ISS_SEL_NONE;
    rstn = 1'b0;
    repeat (8) step;
    rstn <= 1'b1;
    step;
    t_reset();
    t_events();
    t_qerr();
    t_service();
    t_ppoll();
    t_clear();
    close_out();
  end
  // The sequence needs about 120 cycles; this bound leaves a wide margin.
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule
